/* File: verilog/dsm_pkg.sv */
// Constants, enums and carriers for the data-space decoder block.
// Assumes one core clock and a core that issues one access per cycle.
`default_nettype none
package dsm_pkg;
  // ----------------------------------------------------------------
  // Data-space map
  // ----------------------------------------------------------------
  localparam logic [15:0] IO_END       = 16'h003F;
  localparam logic [15:0] SRAM_END     = 16'h005F;
  localparam logic [15:0] IO_SHORT_OFS = 16'h0020;
  localparam logic [15:0] DIRECT_BASE  = 16'h0040;
  localparam logic [15:0] EVT_ADDR     = 16'h003B;
  localparam logic [15:0] SPL_ADDR     = 16'h003D;
  localparam logic [15:0] SPH_ADDR     = 16'h003E;
  localparam logic [15:0] STATUS_FLAGS_ADDR    = 16'h005F;
  localparam logic [15:0] LOCK_BASE    = 16'h3F00;
  localparam logic [15:0] LOCK_END     = 16'h3F01;
  localparam logic [15:0] CFG_BASE     = 16'h3F40;
  localparam logic [15:0] CFG_END      = 16'h3F41;
  localparam logic [15:0] CAL_BASE     = 16'h3F80;
  localparam logic [15:0] CAL_END      = 16'h3F81;
  localparam logic [15:0] ID_BASE      = 16'h3FC0;
  localparam logic [15:0] ID_END       = 16'h3FC3;
  localparam logic [15:0] FLASH_BASE   = 16'h4000;
  localparam logic [15:0] FLASH_END    = 16'h43FF;
  // Serial port registers, excluded from single-bit access
  localparam logic [4:0]  SER_IO_LO    = 5'h10;
  localparam logic [4:0]  SER_IO_HI    = 5'h13;
  localparam int          SRAM_DEPTH   = 32;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] TOP_OF_RAM   = 16'h005F;
  localparam logic [7:0]  STATUS_FLAGS_RST     = 8'h00;
  localparam logic [7:0]  EVT_RST      = 8'h00;
  localparam logic [8:0]  PC_RST       = 9'h000;
  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int F_I = 7;
  localparam int F_T = 6;
  localparam int F_H = 5;
  localparam int F_S = 4;
  localparam int F_V = 3;
  localparam int F_N = 2;
  localparam int F_Z = 1;
  localparam int F_C = 0;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_DIRECT  = 3'b000,
    MODE_IND     = 3'b001,
    MODE_PREDEC  = 3'b010,
    MODE_POSTINC = 3'b011,
    MODE_IO      = 3'b100
  } dsm_mode_t;
  typedef enum logic [2:0] {
    RGN_RSVD = 3'b000,
    RGN_IO   = 3'b001,
    RGN_SRAM = 3'b010,
    RGN_STATUS_FLAGS = 3'b011,
    RGN_NVM  = 3'b100
  } dsm_region_t;
  typedef enum logic [1:0] {
    BOP_NONE = 2'b00,
    BOP_SET  = 2'b01,
    BOP_CLR  = 2'b10,
    BOP_TEST = 2'b11
  } dsm_bop_t;
  typedef struct packed {
    logic        valid;
    logic        wr;
    dsm_mode_t   mode;
    logic [15:0] addr;
    logic [15:0] ptr;
    logic [7:0]  wdata;
  } dsm_mem_req_t;
  typedef struct packed {
    logic        valid;
    dsm_bop_t    op;
    logic [4:0]  io_addr;
    logic [2:0]  bit_idx;
  } dsm_bit_req_t;
  typedef struct packed {
    logic        valid;
    logic [7:0]  mask;
    logic        half;
    logic        ovf;
    logic        carry;
    logic [7:0]  result;
  } dsm_alu_t;
endpackage
`default_nettype wire

/* File: verilog/dsm_core.sv */
// Data-space decoder, stack pointer, status flags and program counter.
// Assumes core-side inputs are on core_clk; NVM read data answers
// nvm_addr_ff within the same cycle.
//
// What this block does
// RULE_01: Stack pointer is two bytes, low byte at 0x3D, reset to top of RAM.
// RULE_02: Short I/O addresses 0x00-0x3F reach data address plus 0x20.
// RULE_03: Status register at 0x5F resets to zero, flags I T H S V N Z C.
// RULE_04: Global enable low blocks every interrupt request.
// RULE_05: Taking an interrupt clears global enable; return sets it.
// RULE_06: Set and clear interrupt instructions drive global enable.
// RULE_07: Bit store copies into T.
// RULE_08: Sign always equals negative XOR overflow.
// RULE_09: ALU results set zero, negative, carry, half carry, overflow.
// RULE_10: Program counter is 9 bits over 512 words, starting at zero.
// RULE_11: Program words appear in data space from 0x4000.
// RULE_12: First 64 addresses are I/O, next 32 are SRAM; here 0x5F decodes as the status register, so SRAM is 0x40-0x5E.
// RULE_13: Lock, config, calibration, ID and flash regions read only.
// RULE_14: Flash window ends 0x43FF; 0x4400 upward is reserved.
// RULE_15: Direct, indirect, pre-decrement and post-increment modes exist.
// RULE_16: Direct mode reaches 0x0040-0x00BF; indirect reaches everything.
// RULE_17: Auto modes decrement before or increment after, then write back.
// RULE_18: A data access completes in two clock cycles.
// RULE_19: Bit set, clear and test act on I/O 0x00-0x1F, not serial.
// RULE_20: Bit set and clear touch only the addressed bit.
// RULE_21: Writing one clears a flag; writing zero leaves it.
// RULE_22: Software writes zero to reserved bits, never to reserved I/O.
// RULE_23: Read-only and reserved writes ignored; reserved reads give zero.
// RULE_24: Status register alike through short I/O and data address.
`timescale 1ns/1ps
`default_nettype none
module dsm_core (
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire dsm_pkg::dsm_mem_req_t mem_req,
  input  wire dsm_pkg::dsm_bit_req_t bit_req,
  input  wire dsm_pkg::dsm_alu_t     alu_upd,
  input  wire logic                  set_interrupt_enable,
  input  wire logic                  clear_interrupt_enable,
  input  wire logic                  irq_taken,
  input  wire logic                  return_from_interrupt,
  input  wire logic                  bit_store_to_copy,
  input  wire logic                  bst_bit,
  input  wire logic                  irq_pending,
  input  wire logic [7:0]            evt_set,
  input  wire logic                  pc_load,
  input  wire logic                  pc_step,
  input  wire logic [8:0]            pc_target,
  input  wire logic [7:0]            nvm_rdata,
  output logic [7:0]                 rd_data_ff,
  output logic                       rd_valid_ff,
  output logic [15:0]                ptr_wb_ff,
  output logic                       ptr_wb_valid_ff,
  output logic                       tested_bit_ff,
  output logic                       test_valid_ff,
  output logic [7:0]                 status_flags_ff,
  output logic [15:0]                stack_pointer_ff,
  output logic                       irq_request_ff,
  output logic                       nvm_rd_ff,
  output logic [15:0]                nvm_addr_ff,
  output logic [8:0]                 program_counter_ff
);
  // ----------------------------------------------------------------
  // Region decode
  // ----------------------------------------------------------------
  function automatic dsm_pkg::dsm_region_t region_of(input logic [15:0] a);
    if (a <= dsm_pkg::IO_END) return dsm_pkg::RGN_IO; // [RULE_12]
    if (a == dsm_pkg::STATUS_FLAGS_ADDR) return dsm_pkg::RGN_STATUS_FLAGS; // [RULE_03]
    if (a <= dsm_pkg::SRAM_END) return dsm_pkg::RGN_SRAM; // [RULE_12]
    if ((a >= dsm_pkg::LOCK_BASE && a <= dsm_pkg::LOCK_END) ||
        (a >= dsm_pkg::CFG_BASE && a <= dsm_pkg::CFG_END) ||
        (a >= dsm_pkg::CAL_BASE && a <= dsm_pkg::CAL_END) ||
        (a >= dsm_pkg::ID_BASE && a <= dsm_pkg::ID_END) ||
        (a >= dsm_pkg::FLASH_BASE && a <= dsm_pkg::FLASH_END)) begin
      return dsm_pkg::RGN_NVM; // [RULE_13] [RULE_14] [RULE_11]
    end
    return dsm_pkg::RGN_RSVD;
  endfunction

  // ----------------------------------------------------------------
  // Stage 1 state and storage
  // ----------------------------------------------------------------
  logic                s1_valid_ff;
  logic                s1_wr_ff;
  dsm_pkg::dsm_bop_t   s1_bop_ff;
  logic [2:0]          s1_bidx_ff;
  dsm_pkg::dsm_region_t s1_rgn_ff;
  logic [15:0]         s1_addr_ff;
  logic [7:0]          s1_wdata_ff;
  logic [7:0]          evt_flags_ff;
  logic [7:0]          sram_mem [dsm_pkg::SRAM_DEPTH];
  logic [7:0]          nxt_status_flags;

  // Effective address per mode
  wire logic [15:0] ptr_dec = mem_req.ptr - 16'h0001;
  wire logic [15:0] ptr_inc = mem_req.ptr + 16'h0001;
  wire logic [15:0] eff_addr =
    (mem_req.mode == dsm_pkg::MODE_DIRECT) ?
      dsm_pkg::DIRECT_BASE + {9'h000, mem_req.addr[6:0]} : // [RULE_16]
    (mem_req.mode == dsm_pkg::MODE_IO) ?
      dsm_pkg::IO_SHORT_OFS + {10'h000, mem_req.addr[5:0]} : // [RULE_02] [RULE_24]
    (mem_req.mode == dsm_pkg::MODE_PREDEC) ? ptr_dec : mem_req.ptr; // [RULE_15]
  wire logic auto_mode = (mem_req.mode == dsm_pkg::MODE_PREDEC) ||
                         (mem_req.mode == dsm_pkg::MODE_POSTINC);

  // Bit access accepted outside the serial registers only
  wire logic bit_serial = (bit_req.io_addr >= dsm_pkg::SER_IO_LO) &&
                          (bit_req.io_addr <= dsm_pkg::SER_IO_HI);
  wire logic bit_ok = bit_req.valid && !mem_req.valid && !bit_serial &&
                      (bit_req.op != dsm_pkg::BOP_NONE); // [RULE_19]
  wire logic [15:0] bit_addr = dsm_pkg::IO_SHORT_OFS + {11'h000, bit_req.io_addr};
  wire logic [15:0] req_addr = mem_req.valid ? eff_addr : bit_addr;
  wire dsm_pkg::dsm_region_t req_rgn = region_of(req_addr);
  wire logic req_go = mem_req.valid || bit_ok;

  // Read mux at stage 1
  wire logic is_spl = s1_addr_ff == dsm_pkg::SPL_ADDR;
  wire logic is_sph = s1_addr_ff == dsm_pkg::SPH_ADDR;
  wire logic is_evt = s1_addr_ff == dsm_pkg::EVT_ADDR;
  wire logic [7:0] io_rd = is_spl ? stack_pointer_ff[7:0] :
                           is_sph ? stack_pointer_ff[15:8] :
                           is_evt ? evt_flags_ff : 8'h00;
  wire logic [7:0] rd_mux =
    (s1_rgn_ff == dsm_pkg::RGN_IO)   ? io_rd :
    (s1_rgn_ff == dsm_pkg::RGN_SRAM) ? sram_mem[s1_addr_ff[4:0]] :
    (s1_rgn_ff == dsm_pkg::RGN_STATUS_FLAGS) ? status_flags_ff :
    (s1_rgn_ff == dsm_pkg::RGN_NVM)  ? nvm_rdata : 8'h00; // [RULE_23]

  // Write value; bit ops build a one-bit mask
  wire logic [7:0] bmask = 8'h01 << s1_bidx_ff;
  wire logic [7:0] wr_val =
    (s1_bop_ff == dsm_pkg::BOP_SET) ? (is_evt ? bmask : rd_mux | bmask) : // [RULE_20]
    (s1_bop_ff == dsm_pkg::BOP_CLR) ? (is_evt ? 8'h00 : rd_mux & ~bmask) : // [RULE_20]
    s1_wdata_ff;
  wire logic do_wr = s1_valid_ff && (s1_wr_ff || s1_bop_ff == dsm_pkg::BOP_SET ||
                                     s1_bop_ff == dsm_pkg::BOP_CLR);
  wire logic wr_io   = do_wr && (s1_rgn_ff == dsm_pkg::RGN_IO);
  wire logic wr_sram = do_wr && (s1_rgn_ff == dsm_pkg::RGN_SRAM);
  wire logic wr_status_flags = do_wr && (s1_rgn_ff == dsm_pkg::RGN_STATUS_FLAGS); // [RULE_24]
  wire logic rd_done = s1_valid_ff && !s1_wr_ff && (s1_bop_ff == dsm_pkg::BOP_NONE);
  wire logic [7:0] evt_clr = (wr_io && is_evt) ? wr_val : 8'h00;
  wire logic [7:0] nxt_evt = (evt_flags_ff & ~evt_clr) | evt_set; // [RULE_21]

  // ----------------------------------------------------------------
  // Status flag next value
  // ----------------------------------------------------------------
  always_comb begin
    nxt_status_flags = status_flags_ff;
    if (wr_status_flags) begin
      nxt_status_flags = wr_val; // [RULE_03]
    end
    if (alu_upd.valid) begin
      if (alu_upd.mask[dsm_pkg::F_H]) nxt_status_flags[dsm_pkg::F_H] = alu_upd.half; // [RULE_09]
      if (alu_upd.mask[dsm_pkg::F_V]) nxt_status_flags[dsm_pkg::F_V] = alu_upd.ovf; // [RULE_09]
      if (alu_upd.mask[dsm_pkg::F_N]) nxt_status_flags[dsm_pkg::F_N] = alu_upd.result[7]; // [RULE_09]
      if (alu_upd.mask[dsm_pkg::F_Z]) nxt_status_flags[dsm_pkg::F_Z] = alu_upd.result == 8'h00; // [RULE_09]
      if (alu_upd.mask[dsm_pkg::F_C]) nxt_status_flags[dsm_pkg::F_C] = alu_upd.carry; // [RULE_09]
    end
    if (bit_store_to_copy) nxt_status_flags[dsm_pkg::F_T] = bst_bit; // [RULE_07]
    if (set_interrupt_enable || return_from_interrupt) nxt_status_flags[dsm_pkg::F_I] = 1'b1; // [RULE_05] [RULE_06]
    if (clear_interrupt_enable || irq_taken) nxt_status_flags[dsm_pkg::F_I] = 1'b0; // [RULE_05] [RULE_06]
    nxt_status_flags[dsm_pkg::F_S] = nxt_status_flags[dsm_pkg::F_N] ^ nxt_status_flags[dsm_pkg::F_V]; // [RULE_08]
  end

  // ----------------------------------------------------------------
  // Pipeline, registers and answers
  // ----------------------------------------------------------------
  // Stage 1 capture of the request
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s1_valid_ff <= 1'b0;
      s1_wr_ff    <= 1'b0;
      s1_bop_ff   <= dsm_pkg::BOP_NONE;
      s1_bidx_ff  <= 3'h0;
      s1_rgn_ff   <= dsm_pkg::RGN_RSVD;
      s1_addr_ff  <= 16'h0000;
      s1_wdata_ff <= 8'h00;
      nvm_rd_ff   <= 1'b0;
      nvm_addr_ff <= 16'h0000;
    end else begin
      s1_valid_ff <= req_go; // [RULE_18]
      s1_wr_ff    <= mem_req.valid && mem_req.wr;
      s1_bop_ff   <= mem_req.valid ? dsm_pkg::BOP_NONE : bit_req.op;
      s1_bidx_ff  <= bit_req.bit_idx;
      s1_rgn_ff   <= req_rgn;
      s1_addr_ff  <= req_addr;
      s1_wdata_ff <= mem_req.wdata;
      nvm_rd_ff   <= req_go && !mem_req.wr && (req_rgn == dsm_pkg::RGN_NVM); // [RULE_13]
      nvm_addr_ff <= req_addr;
    end
  end

  // Pointer write-back for auto modes
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ptr_wb_valid_ff <= 1'b0;
      ptr_wb_ff       <= 16'h0000;
    end else begin
      ptr_wb_valid_ff <= mem_req.valid && auto_mode; // [RULE_17]
      ptr_wb_ff <= (mem_req.mode == dsm_pkg::MODE_PREDEC) ? ptr_dec : ptr_inc; // [RULE_17]
    end
  end

  // Read data and bit test answers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_valid_ff   <= 1'b0;
      rd_data_ff    <= 8'h00;
      test_valid_ff <= 1'b0;
      tested_bit_ff <= 1'b0;
    end else begin
      rd_valid_ff   <= rd_done; // [RULE_18]
      rd_data_ff    <= rd_done ? rd_mux : 8'h00;
      test_valid_ff <= s1_valid_ff && (s1_bop_ff == dsm_pkg::BOP_TEST); // [RULE_19]
      tested_bit_ff <= rd_mux[s1_bidx_ff];
    end
  end

  // SRAM writes; reserved and read-only regions take none
  always_ff @(posedge core_clk) begin
    if (wr_sram) sram_mem[s1_addr_ff[4:0]] <= wr_val; // [RULE_23]
  end

  // Stack pointer, event flags and status
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stack_pointer_ff <= dsm_pkg::TOP_OF_RAM; // [RULE_01]
      evt_flags_ff     <= dsm_pkg::EVT_RST;
      status_flags_ff  <= dsm_pkg::STATUS_FLAGS_RST; // [RULE_03]
    end else begin
      if (wr_io && is_spl) stack_pointer_ff[7:0] <= wr_val; // [RULE_01]
      if (wr_io && is_sph) stack_pointer_ff[15:8] <= wr_val;
      evt_flags_ff    <= nxt_evt;
      status_flags_ff <= nxt_status_flags;
    end
  end

  // Interrupt gate and program counter
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_request_ff     <= 1'b0;
      program_counter_ff <= dsm_pkg::PC_RST; // [RULE_10]
    end else begin
      irq_request_ff <= irq_pending && status_flags_ff[dsm_pkg::F_I]; // [RULE_04]
      if (pc_load) program_counter_ff <= pc_target;
      else if (pc_step) program_counter_ff <= program_counter_ff + 9'h001; // [RULE_10]
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking dsm_cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  property p_sign;
    status_flags_ff[4] == (status_flags_ff[2] ^ status_flags_ff[3]);
  endproperty
  a_sign: assert property (p_sign) else $error("sign flag mismatch"); // [RULE_08]

  property p_irq_gate;
    !status_flags_ff[7] |=> !irq_request_ff;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq passed while disabled"); // [RULE_04]

  property p_taken;
    irq_taken |=> !status_flags_ff[7] ##1 (!irq_request_ff || $past(irq_pending));
  endproperty
  a_taken: assert property (p_taken) else $error("enable kept after interrupt"); // [RULE_05]

  property p_sei;
    (set_interrupt_enable && !clear_interrupt_enable && !irq_taken) |=> status_flags_ff[7];
  endproperty
  a_sei: assert property (p_sei) else $error("enable not set"); // [RULE_06]

  property p_bst;
    bit_store_to_copy |=> status_flags_ff[6] == $past(bst_bit);
  endproperty
  a_bst: assert property (p_bst) else $error("copy bit not stored"); // [RULE_07]

  property p_zero;
    (alu_upd.valid && alu_upd.mask[1]) |=> status_flags_ff[1] == ($past(alu_upd.result) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong"); // [RULE_09]

  property p_rd_two;
    (mem_req.valid && !mem_req.wr) |-> !rd_valid_ff ##1 1'b1 ##1 rd_valid_ff;
  endproperty
  a_rd_two: assert property (p_rd_two) else $error("read not answered in two cycles"); // [RULE_18]

  property p_predec;
    (mem_req.valid && mem_req.mode == dsm_pkg::MODE_PREDEC)
      |=> ptr_wb_valid_ff && ptr_wb_ff == $past(mem_req.ptr) - 16'h0001;
  endproperty
  a_predec: assert property (p_predec) else $error("pre-decrement wrong"); // [RULE_17]

  property p_rsvd_zero;
    (mem_req.valid && !mem_req.wr && mem_req.mode == dsm_pkg::MODE_IND &&
     mem_req.ptr > dsm_pkg::FLASH_END) |-> ##2 rd_data_ff == 8'h00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read not zero"); // [RULE_23]

  c_sram_rd: cover property (rd_done && s1_rgn_ff == dsm_pkg::RGN_SRAM);
  c_irq: cover property (irq_request_ff ##1 irq_taken);
  c_bit_set: cover property (bit_ok && bit_req.op == dsm_pkg::BOP_SET);
endmodule // dsm_core
`default_nettype wire

/* File: verification/dsm_nvm_model.sv */
// Flash, lock and ID byte image behind the decoder's NVM read port.
// Assumes the strobe is on core_clk and data is wanted in the strobe's own cycle.
`timescale 1ns/1ps
`default_nettype none
module dsm_nvm_model (
  input  wire logic        core_clk,
  input  wire logic        nvm_rd_ff,
  input  wire logic [15:0] nvm_addr_ff,
  output var  logic [7:0]  nvm_rdata
);
  // Image byte is the scrambled low address, answered while the strobe stands
  // Outside a read the port shows the inverse, so stale use shows up
  always_comb begin
    if (nvm_rd_ff) nvm_rdata = nvm_addr_ff[7:0] ^ 8'h5A;
    else nvm_rdata = ~(nvm_addr_ff[7:0] ^ 8'h5A);
  end
endmodule // dsm_nvm_model
`default_nettype wire

/* File: verification/data_space_map_status_reg_tb.sv */
// Self-checking bench for the data-space decoder and status flags.
// Assumes dsm_pkg, dsm_core and the NVM image model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module data_space_map_status_reg_tb;
  typedef struct packed {
    logic               wr;
    dsm_pkg::dsm_mode_t m;
    logic [15:0]        a;
    logic [7:0]         d;
    logic [7:0]         er;
    logic [15:0]        ew;
  } dsm_row_t;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  dsm_pkg::dsm_mem_req_t mem_req = '0;
  dsm_pkg::dsm_bit_req_t bit_req = '0;
  dsm_pkg::dsm_alu_t     alu_upd = '0;
  logic [3:0] ctl = 4'h0;
  logic set_interrupt_enable, clear_interrupt_enable, irq_taken, return_from_interrupt;
  logic bit_store_to_copy = 1'b0, bst_bit = 1'b0, irq_pending = 1'b0;
  logic pc_load = 1'b0, pc_step = 1'b0;
  logic [8:0] pc_target = 9'h000;
  logic [7:0] evt_set = 8'h00, nvm_rdata, rd_data_ff, status_flags_ff, rd;
  logic [15:0] ptr_wb_ff, stack_pointer_ff, nvm_addr_ff, wb;
  logic rd_valid_ff, ptr_wb_valid_ff, tested_bit_ff, test_valid_ff, irq_request_ff, nvm_rd_ff;
  logic [8:0] program_counter_ff;
  logic [1:0] tr;
  int err_count = 0;
  int n_tests = 0;
  // Table writes keep reserved bits zero and avoid reserved I/O
  dsm_row_t rows [17] = '{
    '{1'b1, dsm_pkg::MODE_IND, 16'h0045, 8'hA5, 8'h00, 16'h0000},
    '{1'b0, dsm_pkg::MODE_IND, 16'h0045, 8'h00, 8'hA5, 16'h0000},
    '{1'b0, dsm_pkg::MODE_POSTINC, 16'h0045, 8'h00, 8'hA5, 16'h0046},
    '{1'b0, dsm_pkg::MODE_PREDEC, 16'h0046, 8'h00, 8'hA5, 16'h0045},
    '{1'b1, dsm_pkg::MODE_IO, 16'h003F, 8'h2D, 8'h00, 16'h0000},
    '{1'b0, dsm_pkg::MODE_DIRECT, 16'h001F, 8'h00, 8'h2D, 16'h0000},
    '{1'b1, dsm_pkg::MODE_IO, 16'h003F, 8'h04, 8'h00, 16'h0000},
    '{1'b0, dsm_pkg::MODE_IND, 16'h005F, 8'h00, 8'h14, 16'h0000},
    '{1'b1, dsm_pkg::MODE_IO, 16'h001D, 8'h3C, 8'h00, 16'h0000},
    '{1'b0, dsm_pkg::MODE_IND, 16'h003D, 8'h00, 8'h3C, 16'h0000},
    '{1'b0, dsm_pkg::MODE_IND, 16'h4002, 8'h00, 8'h58, 16'h0000},
    '{1'b1, dsm_pkg::MODE_IND, 16'h3F00, 8'hFF, 8'h00, 16'h0000},
    '{1'b0, dsm_pkg::MODE_IND, 16'h3F00, 8'h00, 8'h5A, 16'h0000},
    '{1'b0, dsm_pkg::MODE_IND, 16'h4400, 8'h00, 8'h00, 16'h0000},
    '{1'b0, dsm_pkg::MODE_IND, 16'h0060, 8'h00, 8'h00, 16'h0000},
    '{1'b1, dsm_pkg::MODE_DIRECT, 16'h0005, 8'h77, 8'h00, 16'h0000},
    '{1'b0, dsm_pkg::MODE_IND, 16'h0045, 8'h00, 8'h77, 16'h0000}};
  // Interrupt control pulses share one vector
  assign {return_from_interrupt, irq_taken, clear_interrupt_enable, set_interrupt_enable} = ctl;
  always #2 core_clk = ~core_clk;
  dsm_core DUT (
    .core_clk(core_clk), .nrst(nrst), .mem_req(mem_req), .bit_req(bit_req),
    .alu_upd(alu_upd), .set_interrupt_enable(set_interrupt_enable),
    .clear_interrupt_enable(clear_interrupt_enable), .irq_taken(irq_taken),
    .return_from_interrupt(return_from_interrupt), .bit_store_to_copy(bit_store_to_copy),
    .bst_bit(bst_bit), .irq_pending(irq_pending), .evt_set(evt_set), .pc_load(pc_load),
    .pc_step(pc_step), .pc_target(pc_target), .nvm_rdata(nvm_rdata),
    .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff), .ptr_wb_ff(ptr_wb_ff),
    .ptr_wb_valid_ff(ptr_wb_valid_ff), .tested_bit_ff(tested_bit_ff),
    .test_valid_ff(test_valid_ff), .status_flags_ff(status_flags_ff),
    .stack_pointer_ff(stack_pointer_ff), .irq_request_ff(irq_request_ff),
    .nvm_rd_ff(nvm_rd_ff), .nvm_addr_ff(nvm_addr_ff), .program_counter_ff(program_counter_ff));
  dsm_nvm_model NVM (.core_clk(core_clk), .nvm_rd_ff(nvm_rd_ff), .nvm_addr_ff(nvm_addr_ff),
                     .nvm_rdata(nvm_rdata));
  // Compare and count
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // One data access, answers gathered over the next four cycles
  task automatic mem(input dsm_row_t r, output logic [7:0] d, output logic [15:0] w);
    @(posedge core_clk) mem_req <= '{1'b1, r.wr, r.m, r.a, r.a, r.d};
    @(posedge core_clk) mem_req.valid <= 1'b0;
    d = 8'h00;
    w = 16'h0000;
    repeat (4) begin
      #1;
      if (ptr_wb_valid_ff === 1'b1) w = ptr_wb_ff;
      if (rd_valid_ff === 1'b1) d = rd_data_ff;
      @(posedge core_clk);
    end
  endtask
  // One bit operation, test answer as {valid, bit}
  task automatic bop(input dsm_pkg::dsm_bop_t o, input logic [4:0] io, input logic [2:0] ix,
                     output logic [1:0] t);
    @(posedge core_clk) bit_req <= '{1'b1, o, io, ix};
    @(posedge core_clk) bit_req.valid <= 1'b0;
    t = 2'b00;
    repeat (4) begin
      #1;
      if (test_valid_ff === 1'b1) t = {1'b1, tested_bit_ff};
      @(posedge core_clk);
    end
  endtask
  task automatic pulse(input logic [3:0] v);
    @(posedge core_clk) ctl <= v;
    @(posedge core_clk) ctl <= 4'h0;
    #1;
  endtask
  task automatic alu(input logic [7:0] res, input logic [2:0] hvc, input logic [5:0] e);
    @(posedge core_clk) alu_upd <= '{1'b1, 8'h2F, hvc[2], hvc[1], hvc[0], res};
    @(posedge core_clk) alu_upd.valid <= 1'b0;
    #1 chk("status_flags_ff[5:0]", {10'h000, e}, {10'h000, status_flags_ff[5:0]});
  endtask
  task automatic rst_chk();
    chk("status_flags_ff", 16'h0000, {8'h00, status_flags_ff});
    chk("stack_pointer_ff", 16'h005F, stack_pointer_ff);
    chk("program_counter_ff", 16'h0000, {7'h00, program_counter_ff});
  endtask
  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    step(8);
    rst_chk();
    @(posedge core_clk) nrst <= 1'b1;
    step(2);
    foreach (rows[i]) begin
      mem(rows[i], rd, wb);
      chk("rd_data_ff", {8'h00, rows[i].er}, {8'h00, rd});
      if (rows[i].ew !== 16'h0000) chk("ptr_wb_ff", rows[i].ew, wb);
    end
    $display("Access table done");
    @(posedge core_clk) irq_pending <= 1'b1;
    pulse(4'h1); chk("I after set", 16'h0001, {15'h0, status_flags_ff[7]});
    step(1); chk("irq_request_ff", 16'h0001, {15'h0, irq_request_ff});
    pulse(4'h4); chk("I after irq", 16'h0000, {15'h0, status_flags_ff[7]});
    step(1); chk("irq_request_ff", 16'h0000, {15'h0, irq_request_ff});
    pulse(4'h8); chk("I after return", 16'h0001, {15'h0, status_flags_ff[7]});
    pulse(4'h2); chk("I after clear", 16'h0000, {15'h0, status_flags_ff[7]});
    pulse(4'h1); pulse(4'h3); chk("I set and clear", 16'h0000, {15'h0, status_flags_ff[7]});
    @(posedge core_clk) {bit_store_to_copy, bst_bit} <= 2'b11;
    @(posedge core_clk) bit_store_to_copy <= 1'b0;
    #1 chk("T bit", 16'h0001, {15'h0, status_flags_ff[6]});
    alu(8'h00, 3'b011, 6'h1B);
    alu(8'h80, 3'b110, 6'h2C);
    $display("Flag tests done");
    bop(dsm_pkg::BOP_SET, 5'h1D, 3'h0, tr); chk("stack_pointer_ff", 16'h003D, stack_pointer_ff);
    bop(dsm_pkg::BOP_CLR, 5'h1D, 3'h2, tr); chk("stack_pointer_ff", 16'h0039, stack_pointer_ff);
    bop(dsm_pkg::BOP_TEST, 5'h1D, 3'h3, tr); chk("bit test", 16'h0003, {14'h0, tr});
    bop(dsm_pkg::BOP_TEST, 5'h1D, 3'h2, tr); chk("bit test", 16'h0002, {14'h0, tr});
    bop(dsm_pkg::BOP_TEST, 5'h11, 3'h0, tr); chk("serial bit test", 16'h0000, {14'h0, tr});
    @(posedge core_clk) evt_set <= 8'h03;
    @(posedge core_clk) evt_set <= 8'h00;
    mem('{1'b0, dsm_pkg::MODE_IND, 16'h003B, 8'h00, 8'h00, 16'h0}, rd, wb);
    chk("event flags", 16'h0003, {8'h00, rd});
    mem('{1'b1, dsm_pkg::MODE_IND, 16'h003B, 8'h01, 8'h00, 16'h0}, rd, wb);
    mem('{1'b0, dsm_pkg::MODE_IND, 16'h003B, 8'h00, 8'h00, 16'h0}, rd, wb);
    chk("event flags", 16'h0002, {8'h00, rd});
    bop(dsm_pkg::BOP_SET, 5'h1B, 3'h1, tr);
    mem('{1'b0, dsm_pkg::MODE_IO, 16'h001B, 8'h00, 8'h00, 16'h0}, rd, wb);
    chk("event flags", 16'h0000, {8'h00, rd});
    @(posedge core_clk) {pc_load, pc_target} <= {1'b1, 9'h1FF};
    @(posedge core_clk) {pc_load, pc_step} <= 2'b01;
    #1 chk("program_counter_ff", 16'h01FF, {7'h00, program_counter_ff});
    @(posedge core_clk) pc_step <= 1'b0;
    #1 chk("program_counter_ff", 16'h0000, {7'h00, program_counter_ff});
    $display("Bit, event and counter tests done");
    @(posedge core_clk) nrst <= 1'b0;
    step(2);
    rst_chk();
    $display("Reset test done");
    close_out();
  end
  // Watchdog well past the expected run of about 200 cycles
  initial begin
    #20000;
    err_count++;
    close_out();
  end
endmodule // data_space_map_status_reg_tb
`default_nettype wire
